// file: overload_warning_monitor.sv
// overload warning monitor with avalon-mm register slave
// How it works
// - percent from 0 to 100 enables the early warning.
// - percent above 100 disables the warning; output never asserts.
// - warning threshold is permissible time times stored percent.
// - continuous overload beyond threshold asserts the warning output.
// - overload beyond permissible time raises alarm, display shows alarm code.
// - alarm also asserts the servo fault output.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module overload_warning_monitor #(
  parameter int TICK_CYCLES = overload_warning_pkg::TICK_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        overload_in,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             overload_warning_out,
  output logic             servo_fault_out,
  output logic             digital_out,
  output logic [7:0]       display_code
);

  // scaled compare avoids a divider: t*100 > permit*pct
  function automatic logic exceeds(input logic [31:0] t, input logic [31:0] p, input logic [15:0] pct);
    logic [47:0] lhs;
    logic [47:0] rhs;
    lhs = 48'({16'h0000, t} * 48'h000000000064);
    rhs = 48'({16'h0000, p} * {32'h00000000, pct});
    return lhs > rhs;
  endfunction : exceeds

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  logic                              sync1;
  logic                              sync2;
  logic                              sync3;
  logic                              ol_level;
  logic [31:0]                       prescale;
  logic                              ms_tick;
  logic [31:0]                       ol_ms;
  logic [15:0]                       overload_warn_percent;
  logic [31:0]                       permit_time;
  logic [7:0]                        do_select;
  logic                              alarm;
  logic                              warn_enable;
  logic                              warn_hit;
  logic                              alarm_hit;
  logic                              wr_fire;
  logic                              rd_fire;
  logic [31:0]                       next_readdata;
  logic [31:0]                       merged;
  overload_warning_pkg::bus_state_type bus_state;

  // three stages; only the agreeing later pair steers the level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= overload_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ol_level <= 1'b0;
    end else if (sync2 == sync3) begin
      ol_level <= sync3;
    end
  end

  // millisecond time base
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prescale <= 32'h00000000;
      ms_tick  <= 1'b0;
    end else if (prescale >= 32'(TICK_CYCLES - 1)) begin
      prescale <= 32'h00000000;
      ms_tick  <= 1'b1;
    end else begin
      prescale <= prescale + 32'h00000001;
      ms_tick  <= 1'b0;
    end
  end

  // only uninterrupted overload accumulates; saturates instead of wrapping
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ol_ms <= 32'h00000000;
    end else if (!ol_level) begin
      ol_ms <= 32'h00000000;
    end else if (ms_tick && ol_ms != 32'hffffffff) begin
      ol_ms <= ol_ms + 32'h00000001;
    end
  end

  assign warn_enable = overload_warn_percent <= overload_warning_pkg::PERCENT_FULL;
  assign warn_hit    = warn_enable && ol_level && exceeds(ol_ms, permit_time, overload_warn_percent);
  assign alarm_hit   = ol_level && exceeds(ol_ms, permit_time, overload_warning_pkg::PERCENT_FULL);

  // avalon slave: one wait state, then a single acknowledge cycle
  assign wr_fire = avs_write && bus_state == overload_warning_pkg::bus_ack;
  assign rd_fire = avs_read && bus_state == overload_warning_pkg::bus_idle;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_state       <= overload_warning_pkg::bus_idle;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        overload_warning_pkg::bus_idle: begin
          if (avs_read || avs_write) begin
            bus_state       <= overload_warning_pkg::bus_ack;
            avs_waitrequest <= 1'b0;
          end
        end
        overload_warning_pkg::bus_ack: begin
          bus_state       <= overload_warning_pkg::bus_idle;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state       <= overload_warning_pkg::bus_idle;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    next_readdata = 32'h00000000;
    case (avs_address)
      overload_warning_pkg::OFS_WARN_PERCENT: next_readdata = {16'h0000, overload_warn_percent};
      overload_warning_pkg::OFS_PERMIT_TIME:  next_readdata = permit_time;
      overload_warning_pkg::OFS_STATUS: begin
        next_readdata[overload_warning_pkg::STAT_ALARM_BIT] = alarm;
        next_readdata[overload_warning_pkg::STAT_WARN_BIT]  = overload_warning_out;
        next_readdata[overload_warning_pkg::STAT_LEVEL_BIT] = ol_level;
      end
      overload_warning_pkg::OFS_DO_SELECT:    next_readdata = {24'h000000, do_select};
      overload_warning_pkg::OFS_ELAPSED:      next_readdata = ol_ms;
      default:                                next_readdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_fire) begin
      avs_readdata <= next_readdata;
    end
  end

  assign merged = lane_merge(next_readdata, avs_writedata, avs_byteenable);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overload_warn_percent <= overload_warning_pkg::WARN_PERCENT_RST;
      permit_time           <= overload_warning_pkg::PERMIT_TIME_RST;
      do_select             <= overload_warning_pkg::DO_SELECT_RST;
    end else if (wr_fire) begin
      case (avs_address)
        overload_warning_pkg::OFS_WARN_PERCENT: overload_warn_percent <= merged[15:0];
        overload_warning_pkg::OFS_PERMIT_TIME:  permit_time           <= merged;
        overload_warning_pkg::OFS_DO_SELECT:    do_select             <= merged[7:0];
        default: begin
        end
      endcase
    end
  end

  // alarm is sticky; a new alarm in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarm <= 1'b0;
    end else if (alarm_hit) begin
      alarm <= 1'b1;
    end else if (wr_fire && avs_address == overload_warning_pkg::OFS_STATUS && avs_byteenable[0]
                 && avs_writedata[overload_warning_pkg::STAT_ALARM_BIT]) begin
      alarm <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overload_warning_out <= 1'b0;
      servo_fault_out      <= 1'b0;
      digital_out          <= 1'b0;
      display_code         <= overload_warning_pkg::DISP_NONE;
    end else begin
      overload_warning_out <= warn_hit;
      servo_fault_out      <= alarm || alarm_hit;
      digital_out          <= (do_select == overload_warning_pkg::DO_CODE_WARNING) && warn_hit;
      if (alarm || alarm_hit) begin
        display_code <= overload_warning_pkg::DISP_ALARM;
      end else if (warn_hit) begin
        display_code <= overload_warning_pkg::DISP_WARNING;
      end else begin
        display_code <= overload_warning_pkg::DISP_NONE;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // wide plain arithmetic, kept apart from the helper so a broken helper shows
  property p_enable_warn;
    (ol_level && overload_warn_percent <= 16'h0064
     && 48'(ol_ms) * 48'h000000000064 > 48'(permit_time) * 48'(overload_warn_percent)) |=> overload_warning_out;
  endproperty
  a_enable_warn: assert property (p_enable_warn) else $error("enabled warning not raised");

  property p_disabled_warn;
    overload_warning_out |-> $past(overload_warn_percent) <= 16'h0064;
  endproperty
  a_disabled_warn: assert property (p_disabled_warn) else $error("warning raised while disabled");

  property p_threshold;
    overload_warning_out |-> 48'($past(ol_ms)) * 48'h000000000064
                             > 48'($past(permit_time)) * 48'($past(overload_warn_percent));
  endproperty
  a_threshold: assert property (p_threshold) else $error("warning before threshold");

  property p_warn_level;
    overload_warning_out |-> $past(ol_level);
  endproperty
  a_warn_level: assert property (p_warn_level) else $error("warning without overload");

  property p_alarm_disp;
    alarm |=> display_code == 8'h06;
  endproperty
  a_alarm_disp: assert property (p_alarm_disp) else $error("alarm code not shown");

  property p_do_select;
    (overload_warning_out && do_select == 8'h0a && $past(do_select) == 8'h0a) |-> digital_out;
  endproperty
  a_do_select: assert property (p_do_select) else $error("selected output not following warning");

  property p_fault;
    $rose(alarm) |-> servo_fault_out ##1 servo_fault_out;
  endproperty
  a_fault: assert property (p_fault) else $error("fault output missing");

  property p_clear;
    !ol_level |=> ol_ms == 32'h00000000;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared");

  // only a tick may move the count while overloaded
  property p_count_hold;
    (ol_level && !ms_tick) |=> $stable(ol_ms);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("overload time moved without a tick");

  property p_count_step;
    (ol_level && ms_tick && ol_ms != 32'hffffffff) |=> ol_ms == $past(ol_ms) + 32'h00000001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("overload time not advanced");

  // alarm as a plain compare, not through the helper
  property p_alarm_raise;
    (ol_level && ol_ms > permit_time) |=> alarm;
  endproperty
  a_alarm_raise: assert property (p_alarm_raise) else $error("alarm not raised");

  property p_fault_disp;
    servo_fault_out |-> display_code == overload_warning_pkg::DISP_ALARM;
  endproperty
  a_fault_disp: assert property (p_fault_disp) else $error("fault shown without alarm code");

  property p_warn_disp;
    (overload_warning_out && !servo_fault_out) |-> display_code == overload_warning_pkg::DISP_WARNING;
  endproperty
  a_warn_disp: assert property (p_warn_disp) else $error("warning code not shown");

  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered");

  property p_ack_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("acknowledge longer than one cycle");

  c_warning: cover property (!overload_warning_out ##1 overload_warning_out);
  c_alarm: cover property ($rose(alarm));
  c_clear_alarm: cover property (alarm ##1 !alarm);
  c_write: cover property (wr_fire && avs_address == 12'h138);

endmodule : overload_warning_monitor
`default_nettype wire

// file: overload_warning_pkg.sv
// constants and types for the overload warning monitor
package overload_warning_pkg;
  localparam int          ADDR_WIDTH        = 12;
  localparam logic [11:0] OFS_WARN_PERCENT  = 12'h138;
  localparam logic [11:0] OFS_PERMIT_TIME   = 12'h300;
  localparam logic [11:0] OFS_STATUS        = 12'h304;
  localparam logic [11:0] OFS_DO_SELECT     = 12'h308;
  localparam logic [11:0] OFS_ELAPSED       = 12'h30c;
  localparam logic [15:0] WARN_PERCENT_RST  = 16'h0078;
  localparam logic [15:0] PERCENT_FULL      = 16'h0064;
  localparam logic [31:0] PERMIT_TIME_RST   = 32'h00001f40;
  localparam logic [7:0]  DO_SELECT_RST     = 8'h00;
  localparam logic [7:0]  DO_CODE_WARNING   = 8'h0a;
  localparam logic [7:0]  DISP_NONE         = 8'h00;
  localparam logic [7:0]  DISP_ALARM        = 8'h06;
  localparam logic [7:0]  DISP_WARNING      = 8'h17;
  localparam int          STAT_ALARM_BIT    = 0;
  localparam int          STAT_WARN_BIT     = 1;
  localparam int          STAT_LEVEL_BIT    = 2;
  localparam int          CLOCK_HZ          = 125000000;
  localparam int          TICK_MS           = 1;
  localparam int          TICK_CYCLES       = CLOCK_HZ / 1000 * TICK_MS;
  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_ack  = 2'b01
  } bus_state_type;
endpackage : overload_warning_pkg

// file: overload_load_model.sv
// behavioural model of the motor load that drives the overload level
`timescale 1ns/1ps
`default_nettype none
module overload_load_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic demand,
  output logic      overload_in
);
  // registered so the bench knows on which edge the level changes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overload_in <= 1'b0;
    end else begin
      overload_in <= demand;
    end
  end
endmodule : overload_load_model
`default_nettype wire

// file: overload_warning_monitor_bench.sv
// self-checking bench for the overload warning monitor
`timescale 1ns/1ps
`default_nettype none
module overload_warning_monitor_bench;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        demand = 1'b0;
  logic        overload_in;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        overload_warning_out;
  logic        servo_fault_out;
  logic        digital_out;
  logic [7:0]  display_code;
  logic [31:0] rd;
  int          err_count = 0;
  int          checks = 0;

  always #4 sys_clk = ~sys_clk;

  // short tick keeps the ms counts to a few cycles each
  overload_warning_monitor #(.TICK_CYCLES(4)) DUT (
    .sys_clk(sys_clk), .rst(rst), .overload_in(overload_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .overload_warning_out(overload_warning_out), .servo_fault_out(servo_fault_out),
    .digital_out(digital_out), .display_code(display_code)
  );

  overload_load_model load (.sys_clk(sys_clk), .rst(rst), .demand(demand), .overload_in(overload_in));

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  // holds the request until waitrequest is sampled low; only the watchdog ends a wait
  task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] data, output logic [31:0] rdata);
    @(posedge sys_clk);
    avs_address   <= addr;
    avs_writedata <= data;
    avs_read      <= ~wr;
    avs_write     <= wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // gap is cycles from warning to fault, -1 when no warning may show
  task automatic run_case(input logic [15:0] pct, input int gap, input logic [7:0] dsel);
    int n;
    int w;
    n = 0;
    w = -1;
    bus(1'b1, overload_warning_pkg::OFS_DO_SELECT, {24'h0, dsel}, rd);
    bus(1'b1, overload_warning_pkg::OFS_WARN_PERCENT, {16'h0, pct}, rd);
    @(posedge sys_clk);
    demand <= 1'b1;
    while (servo_fault_out !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (overload_warning_out === 1'b1 && w < 0) begin
        w = n;
        check_word("digital_out", {31'h0, dsel == overload_warning_pkg::DO_CODE_WARNING}, {31'h0, digital_out});
        if (gap > 0) check_word("display_warn", 32'h17, {24'h0, display_code});
      end
    end
    check_word("servo_fault", 32'h1, {31'h0, servo_fault_out});
    check_word("display_alarm", 32'h06, {24'h0, display_code});
    check_word("warn_gap", 32'(gap), 32'(w < 0 ? -1 : n - w));
    bus(1'b0, overload_warning_pkg::OFS_STATUS, 32'h0, rd);
    check_word("status", (gap < 0) ? 32'h00000005 : 32'h00000007, rd);
    @(posedge sys_clk);
    demand <= 1'b0;
    repeat (20) @(posedge sys_clk);
    bus(1'b0, overload_warning_pkg::OFS_ELAPSED, 32'h0, rd);
    check_word("elapsed", 32'h0, rd);
    check_word("warn_off", 32'h0, {31'h0, overload_warning_out});
    bus(1'b1, overload_warning_pkg::OFS_STATUS, 32'h1, rd);
    repeat (3) @(posedge sys_clk);
    #1;
    check_word("fault_clear", 32'h0, {31'h0, servo_fault_out});
    $display("test percent %0d done", pct);
  endtask : run_case

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, overload_warning_pkg::OFS_WARN_PERCENT, 32'h0, rd);
    check_word("percent_rst", {16'h0, overload_warning_pkg::WARN_PERCENT_RST}, rd);
    bus(1'b0, 12'h200, 32'h0, rd);
    check_word("unmapped", 32'h0, rd);
    bus(1'b1, overload_warning_pkg::OFS_WARN_PERCENT, 32'hffff0045, rd);
    bus(1'b0, overload_warning_pkg::OFS_WARN_PERCENT, 32'h0, rd);
    check_word("percent_rw", 32'h00000045, rd);
    avs_byteenable <= 4'h2;
    bus(1'b1, overload_warning_pkg::OFS_WARN_PERCENT, 32'h00001200, rd);
    avs_byteenable <= 4'hf;
    bus(1'b0, overload_warning_pkg::OFS_WARN_PERCENT, 32'h0, rd);
    check_word("percent_lane", 32'h00001245, rd);
    $display("test registers done");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, overload_warning_pkg::OFS_WARN_PERCENT, 32'h0, rd);
    check_word("percent_reset", {16'h0, overload_warning_pkg::WARN_PERCENT_RST}, rd);
    bus(1'b0, overload_warning_pkg::OFS_PERMIT_TIME, 32'h0, rd);
    check_word("permit_reset", overload_warning_pkg::PERMIT_TIME_RST, rd);
    bus(1'b1, overload_warning_pkg::OFS_PERMIT_TIME, 32'h0000000a, rd);
    bus(1'b0, overload_warning_pkg::OFS_PERMIT_TIME, 32'h0, rd);
    check_word("permit_rw", 32'h0000000a, rd);
    $display("test reset done");
    run_case(16'h0000, 40, 8'h0a);
    run_case(16'h003c, 16, 8'h03);
    run_case(16'h0064, 0, 8'h0a);
    run_case(16'h0065, -1, 8'h0a);
    finish_test();
  end

  // whole run needs a few hundred cycles
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule : overload_warning_monitor_bench
`default_nettype wire
